// ### hw/cic_top.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Readouts of consecutive cycles never overlap.
// - Overlap, short next exposure: exp+rdo-nextexp.
// - Overlap, long next exposure: period equals exposure.
// - Five control methods from one select.
// - Uncontrolled method: no trigger, no flash.
// - Rate method: one trigger pulse per cycle.
// - Rate-exposure: trigger width is the exposure.
// - Internal method: controller drives no trigger/flash.
// - External method: controller drives no trigger/flash.
// - External trigger still launches a packet trigger.
// - Late flash: offset after trigger edge.
// - Early flash: trigger delayed after flash.
// - Cycle ends after the light is off; exposure may end first.
// - Four sub-functions: timing, cycle, trigger, sequence.
// - Timing machine makes trigger and flash pulses.
// - Start only when all conditions hold and timing is not busy.
// - Trigger manager derives effective cycle start.
// - Sequences bounded by start and stop conditions.
// - Exposures of consecutive cycles never overlap.
// - No overlap: period is exposure plus readout.
// - Each start gives trigger, flash, permit once.
// - Late flash follows trigger by offset; widths configured.
module cic_top
  import cic_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  // Clock and reset
  input  wire logic             CLOCK_I,
  input  wire logic             NRST_I,
  input  wire logic             CE_I,
  // Configuration
  input  wire logic [2:0]       METHOD_SELECT_I,
  input  wire logic [1:0]       TRIG_SOURCE_I,
  input  wire logic [PEND_W-1:0] MAX_PENDING_I,
  input  wire logic             OVERLAP_I,
  input  wire logic             FLASH_EARLY_I,
  input  wire logic [W-1:0]     EXPOSURE_I,
  input  wire logic [W-1:0]     READOUT_I,
  input  wire logic [W-1:0]     FLASH_OFFSET_I,
  input  wire logic [W-1:0]     FLASH_WIDTH_I,
  input  wire logic [W-1:0]     MIN_PERIOD_I,
  // Sequence and trigger control
  input  wire logic             SEQ_START_I,
  input  wire logic             SEQ_STOP_I,
  input  wire logic             START_CYCLE_I,
  input  wire logic             MEM_FREE_I,
  input  wire logic             EVENT_PIN_I,
  input  wire logic             EXT_TRIG_PIN_I,
  // Outputs to camera and light
  output logic                  CAM_TRIGGER_O,
  output logic                  FLASH_O,
  output logic                  PACKET_TRIGGER_O,
  // Status
  output logic                  SEQ_ACTIVE_O,
  output logic [PEND_W-1:0]     PENDING_COUNT_O,
  output logic                  LOST_TRIGGER_O
);
  logic rst_meta_q;
  logic rst_n_q;
  logic ev_s;
  logic ev_prev_q;
  logic ext_s;
  logic ext_prev_q;
  logic ev_pulse;
  logic ext_pulse;
  logic cyc_trig;
  logic controlled;
  logic busy;
  logic permit;
  logic start;
  logic ready;
  logic imm_wait_q;
  logic [W-1:0] imm_cnt_q;
  logic [W-1:0] exp_t;
  logic [W:0]   exp_sum;
  logic [W-1:0] trig_dly;
  logic [W-1:0] offs_t;
  logic trig_t;
  logic flash_t;
  logic [W-1:0] fwd_cnt_q;
  cic_seq_t seq_q;

  // Reset released through two flops; asserted at once
  always_ff @(posedge CLOCK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  cic_sync2 u_ev_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (rst_n_q),
    .en_i    (CE_I),
    .d_i     (EVENT_PIN_I),
    .q_o     (ev_s)
  );

  cic_sync2 u_ext_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (rst_n_q),
    .en_i    (CE_I),
    .d_i     (EXT_TRIG_PIN_I),
    .q_o     (ext_s)
  );

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ev_prev_q  <= 1'b0;
      ext_prev_q <= 1'b0;
    end else if (CE_I) begin
      ev_prev_q  <= ev_s;
      ext_prev_q <= ext_s;
    end
  end
  assign ev_pulse  = ev_s && !ev_prev_q;
  assign ext_pulse = ext_s && !ext_prev_q;

  assign controlled = (METHOD_SELECT_I == METH_RATE) ||
                      (METHOD_SELECT_I == METH_RATE_EXPO);

  // Sequence manager; stop wins over start
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seq_q <= SEQ_IDLE;
    end else if (CE_I) begin
      case (seq_q)
        SEQ_IDLE: begin
          if (SEQ_START_I && !SEQ_STOP_I && controlled) begin
            seq_q <= SEQ_ACTIVE;
          end
        end
        SEQ_ACTIVE: begin
          if (SEQ_STOP_I || !controlled) begin
            seq_q <= SEQ_IDLE;
          end
        end
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  // Cycle trigger source
  always_comb begin
    if (TRIG_SOURCE_I == TSRC_COMMAND) begin
      cyc_trig = START_CYCLE_I;
    end else if (TRIG_SOURCE_I == TSRC_EVENT) begin
      cyc_trig = ev_pulse;
    end else begin
      cyc_trig = 1'b0;
    end
  end

  assign ready = (seq_q == SEQ_ACTIVE) && !busy && MEM_FREE_I;

  // Immediate source self-triggers when ready, at least a minimum period apart
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      imm_cnt_q  <= CNT_ZERO;
      imm_wait_q <= 1'b0;
    end else if (CE_I) begin
      if (seq_q != SEQ_ACTIVE) begin
        imm_cnt_q  <= CNT_ZERO;
        imm_wait_q <= 1'b0;
      end else if (start) begin
        imm_cnt_q  <= CNT_ONE;
        imm_wait_q <= 1'b1;
      end else if (imm_wait_q && imm_cnt_q < MIN_PERIOD_I) begin
        imm_cnt_q <= imm_cnt_q + CNT_ONE;
      end else begin
        imm_wait_q <= 1'b0;
      end
    end
  end

  // Cycle manager start decision
  always_comb begin
    if (!ready) begin
      start = 1'b0;
    end else if (TRIG_SOURCE_I == TSRC_IMMEDIATE) begin
      start = !imm_wait_q || imm_cnt_q >= MIN_PERIOD_I;
    end else if (MAX_PENDING_I == PEND_ZERO) begin
      start = cyc_trig;
    end else begin
      start = cyc_trig || (PENDING_COUNT_O != PEND_ZERO);
    end
  end

  // Pending and lost trigger bookkeeping
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PENDING_COUNT_O <= PEND_ZERO;
      LOST_TRIGGER_O  <= 1'b0;
    end else if (CE_I) begin
      LOST_TRIGGER_O <= 1'b0;
      if (seq_q != SEQ_ACTIVE) begin
        PENDING_COUNT_O <= PEND_ZERO;
        LOST_TRIGGER_O  <= cyc_trig && controlled &&
                           TRIG_SOURCE_I != TSRC_IMMEDIATE;
      end else if (TRIG_SOURCE_I != TSRC_IMMEDIATE) begin
        if (cyc_trig && !start) begin
          if (PENDING_COUNT_O < MAX_PENDING_I) begin
            PENDING_COUNT_O <= PENDING_COUNT_O + PEND_ONE;
          end else begin
            LOST_TRIGGER_O <= 1'b1;
          end
        end else if (start && !cyc_trig) begin
          PENDING_COUNT_O <= PENDING_COUNT_O - PEND_ONE;
        end
      end
    end
  end

  // Spacing always counts the camera exposure; rate method only narrows
  // the trigger. Early flash: trigger delayed by offset, flash at start
  always_comb begin
    exp_sum  = {1'b0, EXPOSURE_I} + {1'b0, FLASH_OFFSET_I};
    exp_t    = !FLASH_EARLY_I ? EXPOSURE_I :
               exp_sum[W] ? {W{1'b1}} : exp_sum[W-1:0];
    offs_t   = FLASH_EARLY_I ? CNT_ZERO : FLASH_OFFSET_I;
    trig_dly = FLASH_EARLY_I ? FLASH_OFFSET_I : CNT_ZERO;
  end

  cic_timing #(
    .W (W)
  ) u_timing (
    .clk_i        (CLOCK_I),
    .rst_n_i      (rst_n_q),
    .en_i         (CE_I),
    .start_i      (start),
    .expo_i       (exp_t),
    .rdo_i        (READOUT_I),
    .expo_next_i  (EXPOSURE_I),
    .offs_i       (offs_t),
    .width_i      (FLASH_WIDTH_I),
    .min_period_i (MIN_PERIOD_I),
    .overlap_i    (OVERLAP_I),
    .trig_o       (trig_t),
    .flash_o      (flash_t),
    .permit_o     (permit),
    .busy_o       (busy)
  );

  // Early flash shifts the trigger edge behind the flash edge
  logic [W-1:0] early_cnt_q;
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      early_cnt_q <= CNT_ZERO;
    end else if (CE_I) begin
      if (start) begin
        early_cnt_q <= CNT_ZERO;
      end else if (busy && early_cnt_q != {W{1'b1}}) begin
        early_cnt_q <= early_cnt_q + CNT_ONE;
      end
    end
  end

  // Output stage: only controlled methods drive trigger and flash
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      CAM_TRIGGER_O <= 1'b0;
      FLASH_O       <= 1'b0;
      SEQ_ACTIVE_O  <= 1'b0;
    end else if (CE_I) begin
      SEQ_ACTIVE_O <= seq_q == SEQ_ACTIVE;
      if (!controlled) begin
        CAM_TRIGGER_O <= 1'b0;
        FLASH_O       <= 1'b0;
      end else if (METHOD_SELECT_I == METH_RATE) begin
        CAM_TRIGGER_O <= trig_t && (early_cnt_q == trig_dly);
        FLASH_O       <= flash_t;
      end else begin
        CAM_TRIGGER_O <= trig_t && (early_cnt_q >= trig_dly);
        FLASH_O       <= flash_t;
      end
    end
  end

  // Forwarded trigger for packet launch in external methods
  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      PACKET_TRIGGER_O <= 1'b0;
      fwd_cnt_q        <= CNT_ZERO;
    end else if (CE_I) begin
      if ((METHOD_SELECT_I == METH_INTERNAL && ev_pulse) ||
          (METHOD_SELECT_I == METH_EXTERNAL && ext_pulse)) begin
        PACKET_TRIGGER_O <= 1'b1;
        fwd_cnt_q        <= FWD_PULSE_CYC;
      end else if (fwd_cnt_q > CNT_ONE) begin
        fwd_cnt_q <= fwd_cnt_q - CNT_ONE;
      end else begin
        fwd_cnt_q        <= CNT_ZERO;
        PACKET_TRIGGER_O <= 1'b0;
      end
    end
  end

  property p_no_out_uncontrolled;
    @(posedge CLOCK_I) disable iff (!rst_n_q)
    CE_I && !controlled |=> !CAM_TRIGGER_O && !FLASH_O;
  endproperty
  a_no_out_uncontrolled: assert property (p_no_out_uncontrolled)
    else $error("trigger or flash in uncontrolled method");

  property p_start_needs_seq;
    @(posedge CLOCK_I) disable iff (!rst_n_q)
    start |-> seq_q == SEQ_ACTIVE && !busy && MEM_FREE_I;
  endproperty
  a_start_needs_seq: assert property (p_start_needs_seq)
    else $error("cycle started without conditions");

  property p_start_busy;
    @(posedge CLOCK_I) disable iff (!rst_n_q)
    start && CE_I |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("start did not begin a cycle");

  property p_idle_after_reset;
    @(posedge CLOCK_I) disable iff (!rst_n_q)
    seq_q == SEQ_IDLE && !busy |-> !start;
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("start while idle");

  property p_packet_fwd;
    @(posedge CLOCK_I) disable iff (!rst_n_q)
    CE_I && METHOD_SELECT_I == METH_EXTERNAL && ext_pulse |=> PACKET_TRIGGER_O;
  endproperty
  a_packet_fwd: assert property (p_packet_fwd)
    else $error("external trigger not forwarded");

  property p_seq_stop;
    @(posedge CLOCK_I) disable iff (!rst_n_q)
    CE_I && SEQ_STOP_I |=> seq_q == SEQ_IDLE;
  endproperty
  a_seq_stop: assert property (p_seq_stop)
    else $error("sequence did not stop");

  property p_permit_ends;
    @(posedge CLOCK_I) disable iff (!rst_n_q)
    permit |-> !busy;
  endproperty
  a_permit_ends: assert property (p_permit_ends)
    else $error("permit while busy");

  property p_trig_first;
    @(posedge CLOCK_I) disable iff (!rst_n_q)
    CE_I && start && controlled && !FLASH_EARLY_I &&
    FLASH_OFFSET_I != CNT_ZERO |=> ##1 !FLASH_O;
  endproperty
  a_trig_first: assert property (p_trig_first)
    else $error("flash before offset");
endmodule
`default_nettype wire

// ### hw/cic_pkg.sv
package cic_pkg;
  // Counter widths: timing settings in clock cycles, pending trigger count
  localparam int unsigned CNT_W = 24;
  localparam int unsigned PEND_W = 3;
  // Control method encodings
  localparam logic [2:0] METH_UNCONTROLLED = 3'h0;
  localparam logic [2:0] METH_RATE         = 3'h1;
  localparam logic [2:0] METH_RATE_EXPO    = 3'h2;
  localparam logic [2:0] METH_INTERNAL     = 3'h3;
  localparam logic [2:0] METH_EXTERNAL     = 3'h4;
  // Trigger sources
  localparam logic [1:0] TSRC_IMMEDIATE = 2'h0;
  localparam logic [1:0] TSRC_COMMAND   = 2'h1;
  localparam logic [1:0] TSRC_EVENT     = 2'h2;
  // Reset values and unit steps
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 24'h00_0001;
  localparam logic [PEND_W-1:0] PEND_ZERO = 3'h0;
  localparam logic [PEND_W-1:0] PEND_ONE  = 3'h1;
  // Width of the forwarded trigger pulse in external methods
  localparam logic [CNT_W-1:0] FWD_PULSE_CYC = 24'h00_0001;
  // Clock figures
  localparam int unsigned CLK_PERIOD_NS = 100;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ACTIVE} cic_seq_t;
endpackage

// ### hw/cic_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module cic_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic en_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      q_o    <= 1'b0;
    end else if (en_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### hw/cic_timing.sv
`timescale 1ns/10ps
`default_nettype none
// Cycle timing machine: one trigger, one flash, one permit per start
module cic_timing
  import cic_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         en_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] expo_i,
  input  wire logic [W-1:0] rdo_i,
  input  wire logic [W-1:0] expo_next_i,
  input  wire logic [W-1:0] offs_i,
  input  wire logic [W-1:0] width_i,
  input  wire logic [W-1:0] min_period_i,
  input  wire logic         overlap_i,
  output logic              trig_o,
  output logic              flash_o,
  output logic              permit_o,
  output logic              busy_o
);
  logic [W-1:0] t_q;
  logic [W:0]   gap_d;
  logic [W:0]   sum_er;
  logic [W-1:0] gap_q;

  // Required spacing from cycle start to next start
  always_comb begin
    sum_er = {1'b0, expo_i} + {1'b0, rdo_i};
    if (!overlap_i) begin
      gap_d = sum_er;
    end else if (expo_next_i < rdo_i) begin
      gap_d = sum_er - {1'b0, expo_next_i};
    end else begin
      gap_d = {1'b0, expo_i};
    end
    if (gap_d < {1'b0, min_period_i}) begin
      gap_d = {1'b0, min_period_i};
    end
    if (gap_d == {(W+1){1'b0}}) begin
      gap_d = {{W{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o   <= 1'b0;
      t_q      <= CNT_ZERO;
      gap_q    <= CNT_ZERO;
      trig_o   <= 1'b0;
      flash_o  <= 1'b0;
      permit_o <= 1'b0;
    end else if (en_i) begin
      permit_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o  <= 1'b1;
        t_q     <= CNT_ONE;
        gap_q   <= gap_d[W] ? {W{1'b1}} : gap_d[W-1:0];
        trig_o  <= expo_i != CNT_ZERO;
        flash_o <= (offs_i == CNT_ZERO) && (width_i != CNT_ZERO);
      end else if (busy_o) begin
        t_q     <= t_q + CNT_ONE;
        trig_o  <= t_q < expo_i;
        flash_o <= (t_q >= offs_i) && ((t_q - offs_i) < width_i);
        // Offset guard: a late flash must still finish inside its cycle
        if (t_q >= gap_q && t_q >= expo_i && t_q >= offs_i &&
            (t_q - offs_i) >= width_i) begin
          busy_o   <= 1'b0;
          permit_o <= 1'b1;
          trig_o   <= 1'b0;
          flash_o  <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/cic_cam_model.sv
`timescale 1ns/10ps
`default_nettype none
// Camera and light on the far side; flags any cycle it cannot honour
module cic_cam_model #(
  parameter int unsigned CAM_EXPO = 20
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        trig_i,
  input  wire logic        flash_i,
  input  wire logic        gated_i,
  input  wire logic        overlap_i,
  input  wire logic [23:0] rdo_i,
  output logic             overrun_o,
  output logic [15:0]      frames_o,
  output logic [15:0]      flashes_o,
  output logic             light_o
);
  logic        trig_q;
  logic        flash_q;
  logic        expo_on;
  logic [23:0] expo_cnt;
  logic [23:0] rdo_cnt;
  logic        rise;
  logic        end_now;

  assign rise = trig_i && !trig_q;
  // Gated camera ends exposure on the trailing edge, else on its own timer
  assign end_now = expo_on && (gated_i ? !trig_i : (expo_cnt == 24'h00_0001));
  assign light_o = flash_i;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_q    <= 1'b0;
      flash_q   <= 1'b0;
      expo_on   <= 1'b0;
      expo_cnt  <= 24'h00_0000;
      rdo_cnt   <= 24'h00_0000;
      overrun_o <= 1'b0;
      frames_o  <= 16'h0000;
      flashes_o <= 16'h0000;
    end else begin
      trig_q  <= trig_i;
      flash_q <= flash_i;
      if (flash_i && !flash_q) begin
        flashes_o <= flashes_o + 16'h0001;
      end
      if (rdo_cnt != 24'h00_0000) begin
        rdo_cnt <= rdo_cnt - 24'h00_0001;
      end
      if (expo_cnt != 24'h00_0000) begin
        expo_cnt <= expo_cnt - 24'h00_0001;
      end
      if (end_now) begin
        expo_on  <= 1'b0;
        frames_o <= frames_o + 16'h0001;
        rdo_cnt  <= rdo_i - 24'h00_0001;
        if (rdo_cnt != 24'h00_0000) begin
          overrun_o <= 1'b1;
        end
      end
      if (rise) begin
        expo_on  <= 1'b1;
        expo_cnt <= CAM_EXPO[23:0];
        if ((expo_on && !end_now) || (!overlap_i && rdo_cnt != 24'h00_0000)) begin
          overrun_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/test_camera_illumination_cycle_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module test_camera_illumination_cycle_ctrl;
  import cic_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, seq_start = 1'b0, seq_stop = 1'b0;
  logic start_cyc = 1'b0, mem_free = 1'b1, ev_pin = 1'b0, ext_pin = 1'b0;
  logic ovl = 1'b0, early = 1'b0, ce = 1'b1;
  logic [2:0] meth = METH_UNCONTROLLED;
  logic [1:0] src = TSRC_IMMEDIATE;
  logic [PEND_W-1:0] maxp = PEND_ZERO;
  logic [23:0] expo = 24'h00_0014, rdo = 24'h00_001E;
  logic [23:0] offs = 24'h00_0003, wid = 24'h00_0005, minp = 24'h00_000A;
  logic cam_trig, flash, pkt, seq_act, lost, ovr, light;
  logic [PEND_W-1:0] pend;
  logic [15:0] frames, flashes;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  int n_tr, n_fl, n_pk, n_lost, t_tr, t_fl, w_tr, w_fl, gap_min, k;
  logic tr_q = 1'b0, fl_q = 1'b0;

  initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;

  cic_top cic_top_i (.CLOCK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .METHOD_SELECT_I(meth), .TRIG_SOURCE_I(src), .MAX_PENDING_I(maxp),
    .OVERLAP_I(ovl), .FLASH_EARLY_I(early), .EXPOSURE_I(expo),
    .READOUT_I(rdo), .FLASH_OFFSET_I(offs), .FLASH_WIDTH_I(wid),
    .MIN_PERIOD_I(minp), .SEQ_START_I(seq_start), .SEQ_STOP_I(seq_stop),
    .START_CYCLE_I(start_cyc), .MEM_FREE_I(mem_free), .EVENT_PIN_I(ev_pin),
    .EXT_TRIG_PIN_I(ext_pin), .CAM_TRIGGER_O(cam_trig), .FLASH_O(flash),
    .PACKET_TRIGGER_O(pkt), .SEQ_ACTIVE_O(seq_act),
    .PENDING_COUNT_O(pend), .LOST_TRIGGER_O(lost));

  cic_cam_model #(.CAM_EXPO(20)) cic_cam_model_i (.clk_i(clk),
    .rst_n_i(nrst), .trig_i(cam_trig), .flash_i(flash),
    .gated_i(meth == METH_RATE_EXPO), .overlap_i(ovl), .rdo_i(rdo),
    .overrun_o(ovr), .frames_o(frames), .flashes_o(flashes),
    .light_o(light));

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Edge monitor; also bounds the whole run
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      results();
    end
    if (cam_trig === 1'b1 && tr_q !== 1'b1) begin
      if (n_tr > 0 && cyc - t_tr < gap_min) gap_min = cyc - t_tr;
      t_tr = cyc;
      n_tr++;
    end
    if (cam_trig === 1'b0 && tr_q === 1'b1) w_tr = cyc - t_tr;
    if (flash === 1'b1 && fl_q !== 1'b1) begin
      t_fl = cyc;
      n_fl++;
    end
    if (flash === 1'b0 && fl_q === 1'b1) w_fl = cyc - t_fl;
    if (pkt === 1'b1) n_pk++;
    if (lost === 1'b1) n_lost++;
    tr_q = cam_trig;
    fl_q = flash;
  end

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic cfg(input logic [2:0] m, input logic [1:0] s,
                     input logic o, input logic e, input logic [23:0] x);
    @(posedge clk);
    meth <= m; src <= s; ovl <= o; early <= e; expo <= x;
    n_tr = 0; n_fl = 0; n_pk = 0; n_lost = 0; gap_min = 1000000;
  endtask

  task automatic run_seq(input int n);
    @(posedge clk);
    seq_stop <= 1'b0;
    seq_start <= 1'b1;
    for (k = 0; k < 3000 && n_tr < n; k++) @(posedge clk);
    seq_start <= 1'b0;
    seq_stop <= 1'b1;
    waitc(200);
  endtask

  task automatic t_reset_idle();
    cfg(METH_RATE_EXPO, TSRC_IMMEDIATE, 1'b0, 1'b0, 24'h00_0014);
    waitc(30);
    `CHK(n_tr, 0)
    `CHK(seq_act, 1'b0)
  endtask

  task automatic t_rate();
    cfg(METH_RATE, TSRC_IMMEDIATE, 1'b0, 1'b0, 24'h00_0014);
    run_seq(3);
    `CHK(w_tr, 1)
    `CHK(n_fl, n_tr)
    `CHK(gap_min >= 50, 1'b1)
  endtask

  // Spacing table: overlap, exposure, least gap
  task automatic t_spacing();
    int ov[3] = '{0, 1, 1};
    logic [23:0] ex[3] = '{24'h00_0014, 24'h00_0014, 24'h00_0028};
    int gp[3] = '{50, 30, 40};
    for (int i = 0; i < 3; i++) begin
      cfg(METH_RATE_EXPO, TSRC_IMMEDIATE, ov[i][0], 1'b0, ex[i]);
      run_seq(3);
      `CHK(gap_min >= gp[i], 1'b1)
      `CHK(w_tr, ex[i])
      `CHK(t_fl - t_tr, 3)
      `CHK(w_fl, 5)
      `CHK(t_tr + w_tr >= t_fl + w_fl, 1'b1)
    end
  endtask

  task automatic t_early();
    cfg(METH_RATE_EXPO, TSRC_IMMEDIATE, 1'b0, 1'b1, 24'h00_0014);
    run_seq(2);
    `CHK(t_tr - t_fl, 3)
    `CHK(n_fl, n_tr)
  endtask

  task automatic t_no_ctrl();
    logic [2:0] ms[3] = '{METH_UNCONTROLLED, METH_INTERNAL, METH_EXTERNAL};
    for (int i = 0; i < 3; i++) begin
      cfg(ms[i], TSRC_IMMEDIATE, 1'b0, 1'b0, 24'h00_0014);
      seq_start <= 1'b1;
      seq_stop <= 1'b0;
      waitc(5);
      ext_pin <= 1'b1;
      ev_pin <= 1'b1;
      waitc(6);
      ext_pin <= 1'b0;
      ev_pin <= 1'b0;
      waitc(40);
      `CHK(n_tr + n_fl, 0)
      `CHK(n_pk, (i > 0) ? 1 : 0)
      seq_start <= 1'b0;
    end
  endtask

  task automatic t_mem_hold();
    cfg(METH_RATE_EXPO, TSRC_IMMEDIATE, 1'b0, 1'b0, 24'h00_0014);
    mem_free <= 1'b0;
    seq_start <= 1'b1;
    seq_stop <= 1'b0;
    waitc(60);
    `CHK(n_tr, 0)
    mem_free <= 1'b1;
    run_seq(1);
    `CHK(n_tr >= 1, 1'b1)
  endtask

  task automatic t_mid_reset();
    cfg(METH_RATE_EXPO, TSRC_IMMEDIATE, 1'b0, 1'b0, 24'h00_0014);
    seq_stop <= 1'b0;
    seq_start <= 1'b1;
    waitc(10);
    `CHK(cam_trig, 1'b1)
    nrst <= 1'b0;
    seq_start <= 1'b0;
    waitc(2);
    `CHK(cam_trig, 1'b0)
    `CHK(seq_act, 1'b0)
    nrst <= 1'b1;
    waitc(60);
    `CHK(n_tr, 1)
  endtask

  // Enable low mid-trigger: the pulse must stretch by the frozen cycles
  task automatic t_freeze();
    cfg(METH_RATE_EXPO, TSRC_IMMEDIATE, 1'b0, 1'b0, 24'h00_0014);
    seq_stop <= 1'b0;
    seq_start <= 1'b1;
    for (k = 0; k < 100 && n_tr < 1; k++) @(posedge clk);
    ce <= 1'b0;
    seq_start <= 1'b0;
    seq_stop <= 1'b1;
    waitc(30);
    `CHK(cam_trig, 1'b1)
    `CHK(seq_act, 1'b1)
    ce <= 1'b1;
    waitc(200);
    `CHK(w_tr, 50)
    `CHK(n_tr, 1)
  endtask

  task automatic pulse_cmd();
    @(posedge clk);
    start_cyc <= 1'b1;
    @(posedge clk);
    start_cyc <= 1'b0;
    waitc(4);
  endtask

  task automatic t_pending();
    cfg(METH_RATE_EXPO, TSRC_COMMAND, 1'b0, 1'b0, 24'h00_0014);
    maxp <= PEND_ONE;
    seq_stop <= 1'b0;
    seq_start <= 1'b1;
    waitc(40);
    `CHK(n_tr, 0)
    pulse_cmd();
    pulse_cmd();
    `CHK(pend, PEND_ONE)
    pulse_cmd();
    waitc(300);
    `CHK(n_tr, 2)
    `CHK(n_lost, 1)
    seq_start <= 1'b0;
    seq_stop <= 1'b1;
    waitc(10);
    `CHK(seq_act, 1'b0)
  endtask

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    waitc(3);
    t_reset_idle();
    t_mid_reset();
    t_rate();
    t_spacing();
    t_early();
    t_no_ctrl();
    t_mem_hold();
    t_freeze();
    t_pending();
    `CHK(ovr, 1'b0)
    `CHK(flashes == frames, 1'b1)
    results();
  end
endmodule
`default_nettype wire
